/* design/sic_params.svh */
// constants of the reset sequencer and supply monitor
// Function
// R1: all three sources drive pin through delay
// R2: reset vector fetched from FFFE and FFFF
// R3: active, 256/4096 delay, then vector fetch
// R4: vector fetch lasts exactly two cycles
// R5: external pin caught without a clock
// R6: low supply holds static reset
// R7: low supply reset drives pin low
// R8: option enables detector; warning off otherwise
// R9: watchdog drives pin for minimum width
// R10: bit 5 warning flag tracks comparator
// R11: bit 6 enables interrupt on flag change
// R12: pending clears on entering service routine
// R13: interrupt needs enable and cleared mask
// R14: no interrupt for crossing during delay
// R15: enabling while flag set raises one interrupt
// R16: warning wakes from wait, not halt
// R17: register frozen during halt
// R18: bit 4 set on low supply reset
// R19: low supply flag survives other resets
// R20: bit 0 set by watchdog, cleared by low supply
// R21: cause decoded from the two flags
// R22: software keeps bits 7 and 3:1 cleared
// R23: delay starts after release, restarts on source
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH
`define SIC_CSR_ADDR 12'h000
`define SIC_ADDR_MASK 12'hFFC
`define SIC_CSR_RST 8'h00
`define SIC_WATCHDOG_RESET_FLAG_BIT 0
`define SIC_LOW_SUPPLY_RESET_FLAG_BIT 4
`define SIC_SUPPLY_WARNING_FLAG_BIT 5
`define SIC_SUPPLY_WARNING_IRQ_ENABLE_BIT 6
`define SIC_VEC_LO 16'hFFFE
`define SIC_VEC_HI 16'hFFFF
`define SIC_DLY_SHORT 13'h0100
`define SIC_DLY_LONG 13'h1000
`define SIC_FETCH_CYC 2'h2
`define SIC_CLK_NS 32'h28
`define SIC_WDG_PULSE_NS 32'h4E20
`define SIC_WDG_PULSE_CYC ((`SIC_WDG_PULSE_NS + `SIC_CLK_NS - 32'h1) / `SIC_CLK_NS)
`define SIC_RESP_OKAY 2'h0
`define SIC_RESP_SLVERR 2'h2
`endif

/* design/sic_pkg.sv */
// types of the reset sequencer and supply monitor
package sic_pkg;
  // one-hot reset sequence phases
  typedef enum logic [3:0] {
    SIC_ACTIVE = 4'h1,
    SIC_DELAY = 4'h2,
    SIC_FETCH = 4'h4,
    SIC_RUN = 4'h8
  } sic_state_t;
  // reset sources travelling together
  typedef struct packed {
    logic ext;
    logic low_supply_reset_detector;
    logic wdg;
  } sic_src_t;
endpackage

/* design/sic_reset_seq.sv */
// reset sequencer, supply warning flag and cause register with axi4-lite slave
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "sic_params.svh"
module sic_reset_seq
  import sic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic low_supply_in,
  input wire logic supply_warn_cmp,
  input wire logic opt_lvd_en,
  input wire logic opt_long_delay,
  input wire logic wdg_underflow,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_mask,
  input wire logic warn_irq_ack,
  output logic cpu_reset,
  output logic vec_fetch,
  output logic [15:0] vec_addr,
  output logic supply_warn_irq,
  output logic wake_from_wait
);

  // address decode shared by the read and write paths
  function automatic logic sic_hit(input logic [11:0] a);
    sic_hit = (a & `SIC_ADDR_MASK) == `SIC_CSR_ADDR;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pins and option straps

  logic [1:0] pin_s_r; // reset pin level
  logic [1:0] lvd_s_r; // low supply comparator
  logic [1:0] cmp_s_r; // warning comparator
  logic [1:0] opt_lvd_s_r; // detector option
  logic [1:0] opt_long_s_r; // long delay option

  // two flops each; only stage 1 is read by logic
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s_r <= 2'h3;
      lvd_s_r <= 2'h0;
      cmp_s_r <= 2'h0;
      opt_lvd_s_r <= 2'h0;
      opt_long_s_r <= 2'h0;
    end else begin
      pin_s_r <= {pin_s_r[0], rst_pin_in};
      lvd_s_r <= {lvd_s_r[0], low_supply_in};
      cmp_s_r <= {cmp_s_r[0], supply_warn_cmp};
      opt_lvd_s_r <= {opt_lvd_s_r[0], opt_lvd_en};
      opt_long_s_r <= {opt_long_s_r[0], opt_long_delay};
    end
  end

  logic pin_hi;
  logic lvd_on;
  assign pin_hi = pin_s_r[1];
  // detector works only when the option enables it
  assign lvd_on = opt_lvd_s_r[1]; // R8

  ////////////////////////////////////////////////////////////////////////
  // sequence state

  sic_state_t state_r, state_nxt;
  logic [12:0] dly_cnt_r, dly_cnt_nxt; // stabilisation delay
  logic [1:0] fetch_cnt_r, fetch_cnt_nxt; // vector fetch cycles
  logic [9:0] wdg_cnt_r, wdg_cnt_nxt; // watchdog pin pulse
  logic rst_pin_oe_r, rst_pin_oe_nxt; // pin pulled low
  logic own_mask_r, own_mask_nxt; // hides our own drive
  logic rst_pin_do_r; // open-drain data, always low
  logic vec_fetch_r, vec_fetch_nxt;
  logic [15:0] vec_addr_r, vec_addr_nxt;
  logic ext_seen_r, ext_seen_nxt; // external reset caught
  logic cpu_reset_r, cpu_reset_nxt;
  logic ext_det_n; // pin as seen by the async catcher
  sic_src_t src; // live reset sources
  logic any_src;

  // our own drive and its trailing edge must not look like an external reset
  assign ext_det_n = rst_pin_in | rst_pin_oe_r | own_mask_r;

  // sources of reset
  always_comb begin
    src.ext = ext_seen_r;
    src.low_supply_reset_detector = lvd_s_r[1] & lvd_on; // R6
    src.wdg = wdg_underflow | (wdg_cnt_r != 10'h000); // R9
    any_src = src.ext | src.low_supply_reset_detector | src.wdg; // R1
  end

  // next state of the sequence
  always_comb begin
    state_nxt = state_r;
    dly_cnt_nxt = dly_cnt_r;
    fetch_cnt_nxt = fetch_cnt_r;
    wdg_cnt_nxt = wdg_cnt_r;
    // watchdog pulse width counter
    if (wdg_underflow) begin
      wdg_cnt_nxt = 10'(`SIC_WDG_PULSE_CYC); // R9
    end else if (wdg_cnt_r != 10'h000) begin
      wdg_cnt_nxt = wdg_cnt_r - 10'h001;
    end
    unique case (state_r)
      SIC_ACTIVE: begin
        // delay length follows the option strap
        dly_cnt_nxt = opt_long_s_r[1] ? `SIC_DLY_LONG : `SIC_DLY_SHORT; // R3
        if (!any_src) begin
          state_nxt = SIC_DELAY; // R23
        end
      end
      SIC_DELAY: begin
        if (any_src) begin
          state_nxt = SIC_ACTIVE; // R23
        end else if (dly_cnt_r == 13'h0001) begin
          state_nxt = SIC_FETCH; // R3
          fetch_cnt_nxt = `SIC_FETCH_CYC;
        end else begin
          dly_cnt_nxt = dly_cnt_r - 13'h0001;
        end
      end
      SIC_FETCH: begin
        if (any_src) begin
          state_nxt = SIC_ACTIVE;
        end else if (fetch_cnt_r == 2'h1) begin
          state_nxt = SIC_RUN; // R4
        end else begin
          fetch_cnt_nxt = fetch_cnt_r - 2'h1;
        end
      end
      SIC_RUN: begin
        if (any_src) begin
          state_nxt = SIC_ACTIVE;
        end
      end
    endcase
  end

  // pin drive, vector address and core reset
  always_comb begin
    // external reset already pulls the pin, so only internal sources drive it
    rst_pin_oe_nxt = (state_nxt == SIC_DELAY) // R1
                   | ((state_nxt == SIC_ACTIVE) & (src.low_supply_reset_detector | src.wdg)); // R7
    // mask stays until the released pin is seen high again
    own_mask_nxt = rst_pin_oe_nxt | (own_mask_r & ~pin_hi);
    vec_fetch_nxt = state_nxt == SIC_FETCH;
    // first fetch cycle reads the low byte, second the high byte
    if (vec_fetch_nxt && fetch_cnt_nxt == `SIC_FETCH_CYC) begin
      vec_addr_nxt = `SIC_VEC_LO; // R2
    end else if (vec_fetch_nxt) begin
      vec_addr_nxt = `SIC_VEC_HI; // R2
    end else begin
      vec_addr_nxt = `SIC_VEC_LO;
    end
    // external catch clears once the outside releases the pin
    ext_seen_nxt = ext_seen_r & ~(pin_hi & ~own_mask_r & ~rst_pin_oe_r);
    // core stays held through both fetch cycles; it runs from the first run cycle
    cpu_reset_nxt = ext_seen_nxt
                  | (state_nxt == SIC_ACTIVE)
                  | (state_nxt == SIC_DELAY)
                  | (state_nxt == SIC_FETCH); // R4
  end

  // sequence registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= SIC_ACTIVE;
      dly_cnt_r <= `SIC_DLY_SHORT;
      fetch_cnt_r <= 2'h0;
      wdg_cnt_r <= 10'h000;
      rst_pin_oe_r <= 1'b1;
      own_mask_r <= 1'b1;
      rst_pin_do_r <= 1'b0;
      vec_fetch_r <= 1'b0;
      vec_addr_r <= `SIC_VEC_LO;
    end else begin
      state_r <= state_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      fetch_cnt_r <= fetch_cnt_nxt;
      wdg_cnt_r <= wdg_cnt_nxt;
      rst_pin_oe_r <= rst_pin_oe_nxt;
      own_mask_r <= own_mask_nxt;
      rst_pin_do_r <= 1'b0;
      vec_fetch_r <= vec_fetch_nxt;
      vec_addr_r <= vec_addr_nxt;
    end
  end

  // a low pin enters reset with no clock running, e.g. in halt
  always_ff @(posedge core_clk or posedge rst or negedge ext_det_n) begin
    if (rst) begin
      ext_seen_r <= 1'b0;
      cpu_reset_r <= 1'b1;
    end else if (!ext_det_n) begin
      ext_seen_r <= 1'b1; // R5
      cpu_reset_r <= 1'b1; // R5
    end else begin
      ext_seen_r <= ext_seen_nxt;
      cpu_reset_r <= cpu_reset_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_data_r, w_data_nxt; // only the low lane holds bits
  logic w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic wr_fire; // both halves held, write done now
  logic csr_wr; // write hits the register lane
  logic [7:0] csr_rd; // register read view

  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  // writes during halt are answered but dropped
  assign csr_wr = wr_fire & sic_hit(aw_addr_r) & w_strb_r & ~halt_mode; // R17

  // channel handshakes
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    // address and data accepted in either order
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_strb_nxt = s_axi_wstrb[0];
    end
    // response once both halves are in
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = sic_hit(aw_addr_r) ? `SIC_RESP_OKAY : `SIC_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // read data captured at the address handshake
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = sic_hit(s_axi_araddr) ? {24'h000000, csr_rd} : 32'h00000000;
      rresp_nxt = sic_hit(s_axi_araddr) ? `SIC_RESP_OKAY : `SIC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // one transfer each way at a time
    awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
    wready_nxt = ~w_got_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // bus registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `SIC_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `SIC_RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supply integrity control/status register

  logic ie_r, ie_nxt; // warning interrupt enable
  logic supply_warning_flag_r, supply_warning_flag_nxt; // warning flag
  logic low_supply_reset_flag_r, low_supply_reset_flag_nxt; // low supply reset cause
  logic watchdog_reset_flag_r, watchdog_reset_flag_nxt; // watchdog reset cause
  logic pend_r, pend_nxt; // pending warning interrupt
  logic irq_r, irq_nxt;
  logic wake_r, wake_nxt;
  // reset image kept constant so the async reset branch loads constants only
  localparam logic [7:0] CSR_RST = `SIC_CSR_RST;

  // reserved bits read as zero whatever software wrote
  always_comb begin
    csr_rd = 8'h00; // R22
    csr_rd[`SIC_SUPPLY_WARNING_IRQ_ENABLE_BIT] = ie_r;
    csr_rd[`SIC_SUPPLY_WARNING_FLAG_BIT] = supply_warning_flag_r;
    csr_rd[`SIC_LOW_SUPPLY_RESET_FLAG_BIT] = low_supply_reset_flag_r;
    csr_rd[`SIC_WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_r;
  end

  // flag, interrupt and cause updates
  always_comb begin
    // comparator mirrored live, held in halt, zero when detector off
    supply_warning_flag_nxt = halt_mode ? supply_warning_flag_r : (cmp_s_r[1] & lvd_on); // R10 R17 R8
    ie_nxt = csr_wr ? w_data_r[`SIC_SUPPLY_WARNING_IRQ_ENABLE_BIT] : ie_r; // R11
    pend_nxt = pend_r;
    if (!halt_mode) begin
      // acknowledge first so a new event in the same cycle wins
      if (warn_irq_ack) begin
        pend_nxt = 1'b0; // R12
      end
      // crossings inside the reset sequence are ignored
      if (ie_r && (supply_warning_flag_nxt != supply_warning_flag_r) && state_r == SIC_RUN) begin
        pend_nxt = 1'b1; // R11 R14
      end
      // enabling while the flag is still up raises one request
      if (csr_wr && w_data_r[`SIC_SUPPLY_WARNING_IRQ_ENABLE_BIT] && !ie_r && supply_warning_flag_r) begin
        pend_nxt = 1'b1; // R15
      end
    end
    irq_nxt = pend_nxt & ie_nxt & ~cpu_irq_mask; // R13
    // wait exit only; in halt nothing moves
    wake_nxt = pend_nxt & ie_nxt & wait_mode & ~halt_mode; // R16
    // low supply flag: set wins, other resets leave it alone
    low_supply_reset_flag_nxt = low_supply_reset_flag_r;
    if (src.low_supply_reset_detector) begin
      low_supply_reset_flag_nxt = 1'b1; // R18 R19
    end else if (csr_wr && !w_data_r[`SIC_LOW_SUPPLY_RESET_FLAG_BIT]) begin
      low_supply_reset_flag_nxt = 1'b0; // R18
    end
    // watchdog flag: low supply reset clears, underflow sets
    watchdog_reset_flag_nxt = watchdog_reset_flag_r;
    if (src.low_supply_reset_detector) begin
      watchdog_reset_flag_nxt = 1'b0; // R20 R21
    end else if (wdg_underflow) begin
      watchdog_reset_flag_nxt = 1'b1; // R20
    end else if (csr_wr && !w_data_r[`SIC_WATCHDOG_RESET_FLAG_BIT]) begin
      watchdog_reset_flag_nxt = 1'b0; // R20
    end
  end

  // register state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ie_r <= CSR_RST[`SIC_SUPPLY_WARNING_IRQ_ENABLE_BIT];
      supply_warning_flag_r <= CSR_RST[`SIC_SUPPLY_WARNING_FLAG_BIT];
      low_supply_reset_flag_r <= CSR_RST[`SIC_LOW_SUPPLY_RESET_FLAG_BIT];
      watchdog_reset_flag_r <= CSR_RST[`SIC_WATCHDOG_RESET_FLAG_BIT];
      pend_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      ie_r <= ie_nxt;
      supply_warning_flag_r <= supply_warning_flag_nxt;
      low_supply_reset_flag_r <= low_supply_reset_flag_nxt;
      watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
      pend_r <= pend_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rst_pin_out = rst_pin_do_r;
  assign rst_pin_oe = rst_pin_oe_r;
  assign cpu_reset = cpu_reset_r;
  assign vec_fetch = vec_fetch_r;
  assign vec_addr = vec_addr_r;
  assign supply_warn_irq = irq_r;
  assign wake_from_wait = wake_r;

endmodule

/* dv/sic_reset_seq_sva.sv */
// concurrent checks on the reset sequencer ports
`timescale 1ns/10ps
module sic_reset_seq_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic rst_pin_oe,
  input wire logic low_supply_in,
  input wire logic opt_lvd_en,
  input wire logic wdg_underflow,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_mask,
  input wire logic cpu_reset,
  input wire logic vec_fetch,
  input wire logic [15:0] vec_addr,
  input wire logic supply_warn_irq,
  input wire logic wake_from_wait
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_FETCH_TWO: assert property ($rose(vec_fetch) |=> vec_fetch ##1 !vec_fetch)
    else $error("vector fetch length wrong");
  AST_VEC_ADDR: assert property ($rose(vec_fetch) |-> vec_addr == 16'hFFFE ##1 vec_addr == 16'hFFFF)
    else $error("vector address order wrong");
  AST_PIN_DELAY: assert property ($rose(vec_fetch) |-> $past(rst_pin_oe))
    else $error("pin released before delay end");
  AST_RUN_AFTER_FETCH: assert property ($fell(cpu_reset) |-> $past(vec_fetch) && $past(vec_fetch, 2))
    else $error("cpu released without fetch");
  AST_WDG_ENTRY: assert property (wdg_underflow && !cpu_reset |=> cpu_reset && rst_pin_oe)
    else $error("watchdog did not reset");
  AST_WDG_HOLD: assert property ($rose(cpu_reset) && $past(wdg_underflow) |-> rst_pin_oe [*8])
    else $error("watchdog pin pulse short");
  AST_LVD_STATIC: assert property ((low_supply_in && opt_lvd_en) [*5] |-> cpu_reset && rst_pin_oe)
    else $error("low supply not holding reset");
  AST_IRQ_MASK: assert property (supply_warn_irq |-> !$past(cpu_irq_mask))
    else $error("interrupt while masked");
  AST_WAKE: assert property (wake_from_wait |-> $past(wait_mode) && !$past(halt_mode))
    else $error("wake outside wait");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind sic_reset_seq sic_reset_seq_chk i_chk (.*);

/* dv/sic_ext_rst_model.sv */
// external reset circuitry on the open-drain reset pin
`timescale 1ns/10ps
module sic_ext_rst_model #(
  parameter int MIN_CYC = 4
) (
  input wire logic core_clk,
  input wire logic dut_oe,
  input wire logic pull_req,
  output logic pin_level
);
  int hold_r = 0; // cycles the pull is stretched
  // stretch every pull so a short request still meets the minimum width
  always @(posedge core_clk) begin
    if (pull_req) begin
      hold_r <= MIN_CYC;
    end else if (hold_r > 0) begin
      hold_r <= hold_r - 1;
    end
  end
  // any low driver wins, otherwise the pull-up lifts the wire
  assign pin_level = (dut_oe || pull_req || hold_r > 0) ? 1'b0 : 1'b1;
endmodule

/* dv/sic_reset_seq_tb_top.sv */
// self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/10ps
module sic_reset_seq_tb_top;
  logic core_clk, rst, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, got;
  logic [1:0] br, rr, rsp;
  logic [7:0] d;
  logic pin, oe, pout, lsi, cmp, lvd_en, long_dly, wdg, halt, wt, msk, ack, pull;
  logic cres, vf, irq, wake;
  logic [15:0] va;
  int fails, check_count, seed, c;
  int exp_en, exp_lv, exp_wd, exp_fl; // reference register contents
  ////////////////////////////////////////
  sic_reset_seq i_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .rst_pin_in(pin), .rst_pin_out(pout), .rst_pin_oe(oe), .low_supply_in(lsi), .supply_warn_cmp(cmp),
    .opt_lvd_en(lvd_en), .opt_long_delay(long_dly), .wdg_underflow(wdg), .halt_mode(halt), .wait_mode(wt),
    .cpu_irq_mask(msk), .warn_irq_ack(ack), .cpu_reset(cres), .vec_fetch(vf), .vec_addr(va),
    .supply_warn_irq(irq), .wake_from_wait(wake));
  sic_ext_rst_model i_ext (.core_clk(core_clk), .dut_oe(oe), .pull_req(pull), .pin_level(pin));
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // a used-up bound counts as a mismatch and closes the run
  task automatic to(input int n);
    if (n >= 6000) begin
      chk(32'h1, 32'h0);
      end_of_test();
    end
  endtask
  // bus write: both channels offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      // late bready leaves the response standing one cycle unaccepted
      if (n == 3) bry <= 1'b1;
    end while (!(bv === 1'b1 && bry === 1'b1) && n < 6000);
    rsp = br;
    bry <= 1'b0;
    to(n);
    @(posedge core_clk);
  endtask
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 6000);
    got = rd;
    rsp = rr;
    rry <= 1'b0;
    to(n);
    @(posedge core_clk);
  endtask
  // counts cycles until the cpu leaves reset
  task automatic run();
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (cres !== 1'b0 && c < 6000);
    to(c);
  endtask
  task automatic pulse_ack();
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(2);
  endtask
  function automatic logic [31:0] exp_csr();
    return {25'h0, exp_en[0], exp_fl[0], exp_lv[0], 3'h0, exp_wd[0]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 85863;
    {fails, check_count, exp_en, exp_lv, exp_wd, exp_fl} = '0;
    {awa, ara, wd} = '0;
    {rst, awv, wv, bry, arv, rry, lsi, cmp, lvd_en, long_dly, wdg, halt, wt, msk, ack, pull} = 16'h8080;
    cyc(16);
    rst <= 1'b0;
    run();
    chk(c >= 258 && c <= 262, 1);
    rdr(12'h000);
    chk(got, exp_csr());
    rdr(12'h010);
    chk({rsp, got[29:0]}, 32'h80000000);
    d = 8'($random(seed));
    wr(12'h000, d & 8'h71);
    exp_en = d[6];
    rdr(12'h000);
    chk(got, exp_csr());
    wr(12'h004, 8'h40);
    chk(rsp, 2'h2);
    $display("test registers done");
    wr(12'h000, 8'h40);
    exp_en = 1;
    cmp <= 1'b1;
    exp_fl = 1;
    cyc(6);
    chk(irq, 1);
    rdr(12'h000);
    chk(got, exp_csr());
    pulse_ack();
    chk(irq, 0);
    msk <= 1'b1;
    cmp <= 1'b0;
    exp_fl = 0;
    cyc(6);
    chk(irq, 0);
    wt <= 1'b1;
    cyc(3);
    chk(wake, 1);
    msk <= 1'b0;
    cyc(3);
    chk(irq, 1);
    wt <= 1'b0;
    pulse_ack();
    wr(12'h000, 8'h00);
    exp_en = 0;
    cmp <= 1'b1;
    exp_fl = 1;
    cyc(6);
    chk(irq, 0);
    wr(12'h000, 8'h40);
    exp_en = 1;
    cyc(2);
    chk(irq, 1);
    pulse_ack();
    halt <= 1'b1;
    cmp <= 1'b0;
    cyc(6);
    wr(12'h000, 8'h00);
    rdr(12'h000);
    chk(got, exp_csr());
    halt <= 1'b0;
    exp_fl = 0;
    cyc(6);
    rdr(12'h000);
    chk(got, exp_csr());
    chk(irq, 1);
    pulse_ack();
    $display("test interrupt done");
    wdg <= 1'b1;
    cyc(1);
    wdg <= 1'b0;
    run();
    chk(c >= 756 && c <= 766, 1);
    exp_wd = 1;
    rdr(12'h000);
    chk(got & 32'h11, exp_csr() & 32'h11);
    $display("test watchdog done");
    lsi <= 1'b1;
    cyc(20);
    chk({cres, oe, pout}, 3'h6);
    cmp <= 1'b1;
    lsi <= 1'b0;
    cyc(10);
    cmp <= 1'b0;
    run();
    chk(c >= 248 && c <= 256, 1);
    chk(irq, 0);
    exp_lv = 1;
    exp_wd = 0;
    rdr(12'h000);
    chk(got & 32'h11, exp_csr() & 32'h11);
    $display("test low supply done");
    long_dly <= 1'b1;
    halt <= 1'b1;
    cyc(8);
    pull <= 1'b1;
    cyc(2);
    chk(cres, 1);
    pull <= 1'b0;
    halt <= 1'b0;
    run();
    chk(c >= 4098 && c <= 4120, 1);
    rdr(12'h000);
    chk(got & 32'h11, exp_csr() & 32'h11);
    wr(12'h000, 8'h00);
    exp_lv = 0;
    rdr(12'h000);
    chk(got & 32'h11, exp_csr() & 32'h11);
    $display("test external done");
    end_of_test();
  end
endmodule
